//--- design/motor_cmd_pkg.sv
package motor_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (word addresses on the serial register map)
  localparam logic [15:0] ADDR_RUN_CMD   = 16'h2000;
  localparam logic [15:0] ADDR_FREQ_SET  = 16'h2001;
  localparam logic [15:0] ADDR_PID_REF   = 16'h2002;
  localparam logic [15:0] ADDR_PID_FB    = 16'h2003;
  localparam logic [15:0] ADDR_TORQUE    = 16'h2004;
  localparam logic [15:0] ADDR_FWD_CEIL  = 16'h2005;
  localparam logic [15:0] ADDR_REV_CEIL  = 16'h2006;
  localparam logic [15:0] ADDR_MOT_LIM   = 16'h2007;
  localparam logic [15:0] ADDR_BRK_LIM   = 16'h2008;
  localparam logic [15:0] ADDR_SPECIAL   = 16'h2009;
  localparam logic [15:0] ADDR_VIRT_IN   = 16'h200a;
  localparam logic [15:0] ADDR_VIRT_OUT  = 16'h200b;
  localparam logic [15:0] ADDR_VOLT_SET  = 16'h200c;
  localparam logic [15:0] ADDR_AO1_SET   = 16'h200d;
  localparam logic [15:0] ADDR_AO2_SET   = 16'h200e;
  localparam logic [15:0] ADDR_STATE_ONE = 16'h2100;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [15:0] CMD_FWD_RUN     = 16'h0001;
  localparam logic [15:0] CMD_REV_RUN     = 16'h0002;
  localparam logic [15:0] CMD_FWD_JOG     = 16'h0003;
  localparam logic [15:0] CMD_REV_JOG     = 16'h0004;
  localparam logic [15:0] CMD_STOP        = 16'h0005;
  localparam logic [15:0] CMD_COAST       = 16'h0006;
  localparam logic [15:0] CMD_FAULT_RESET = 16'h0007;
  localparam logic [15:0] CMD_JOG_STOP    = 16'h0008;

  // drive state word codes
  localparam logic [15:0] ST_FWD_RUN   = 16'h0001;
  localparam logic [15:0] ST_REV_RUN   = 16'h0002;
  localparam logic [15:0] ST_STOPPED   = 16'h0003;
  localparam logic [15:0] ST_FAULT     = 16'h0004;
  localparam logic [15:0] ST_POWER_OFF = 16'h0005;
  localparam logic [15:0] ST_PREEXC    = 16'h0006;

  ////////////////////////////////////////////////////////////////////////////
  // value ranges, 1000 = 100 %
  localparam logic [15:0] PCT_FULL     = 16'h03e8;
  localparam logic [15:0] TORQUE_MAX   = 16'h0bb8;
  localparam logic [15:0] VIRT_IN_MAX  = 16'h03ff;
  localparam logic [15:0] VIRT_OUT_MAX = 16'h000f;
  localparam logic [15:0] SPECIAL_MASK = 16'h003f;

  // special control word fields
  localparam int SP_MOTOR_LSB  = 0;
  localparam int SP_TORQUE_OFF = 2;
  localparam int SP_ENERGY_CLR = 3;
  localparam int SP_PREEXC     = 4;
  localparam int SP_DC_BRAKE   = 5;

  // reset values
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [15:0] CEIL_RESET = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] run_command_code;
    logic [15:0] frequency_setpoint;
    logic [15:0] pid_reference;
    logic [15:0] pid_feedback;
    logic [15:0] torque_setpoint;
    logic [15:0] forward_freq_ceiling;
    logic [15:0] reverse_freq_ceiling;
    logic [15:0] motoring_torque_ceiling;
    logic [15:0] braking_torque_ceiling;
    logic [15:0] special_control_word;
    logic [15:0] virtual_input_image;
    logic [15:0] virtual_output_image;
    logic [15:0] voltage_setpoint;
    logic [15:0] analog_out_one_setpoint;
    logic [15:0] analog_out_two_setpoint;
  } ctrl_regs_t;

  typedef struct packed {
    logic [1:0] motor_sel;
    logic       torque_ctrl_off;
    logic       preexcite;
    logic       dc_brake;
  } special_t;

  typedef struct packed {
    logic relay_output_two;
    logic relay_output_one;
    logic high_speed_pulse_output;
    logic open_collector_output;
  } virt_out_t;

  typedef struct packed {
    logic running;
    logic reverse;
    logic fault;
    logic undervoltage_power_down_state;
    logic preexcited;
  } drive_status_t;

endpackage

//--- design/motor_cmd_regs.sv
`timescale 1ns/1ps
module motor_cmd_regs (
  // clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  // register access
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [15:0]                   i_reg_addr,
  input  wire logic [15:0]                   i_reg_wdata,
  output logic                               o_reg_ack,
  output logic                               o_reg_err,
  output logic [15:0]                        o_reg_rdata,
  // drive side status
  input  wire logic [15:0]                   i_fmax,
  input  wire motor_cmd_pkg::drive_status_t  i_drive,
  // command pulses
  output logic                               o_cmd_strobe,
  output logic                               o_fault_reset,
  output logic                               o_jog_stop,
  output logic                               o_energy_clr,
  // setpoints and images
  output motor_cmd_pkg::ctrl_regs_t          o_ctrl,
  output logic [15:0]                        o_freq_ref,
  output motor_cmd_pkg::special_t            o_special,
  output logic [9:0]                         o_virt_in,
  output motor_cmd_pkg::virt_out_t           o_virt_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic signed_within(input logic [15:0] v, input logic [15:0] lim);
    signed_within = ($signed(v) >= -$signed(lim)) && ($signed(v) <= $signed(lim));
  endfunction

  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  function automatic logic write_ok(input logic [15:0] a, input logic [15:0] d,
                                    input logic [15:0] fmax);
    case (a)
      motor_cmd_pkg::ADDR_RUN_CMD:  write_ok = (d >= motor_cmd_pkg::CMD_FWD_RUN) &&
                                               (d <= motor_cmd_pkg::CMD_JOG_STOP);
      motor_cmd_pkg::ADDR_FREQ_SET: write_ok = (d <= fmax);
      motor_cmd_pkg::ADDR_FWD_CEIL: write_ok = (d <= fmax);
      motor_cmd_pkg::ADDR_REV_CEIL: write_ok = (d <= fmax);
      motor_cmd_pkg::ADDR_PID_REF:  write_ok = (d <= motor_cmd_pkg::PCT_FULL);
      motor_cmd_pkg::ADDR_PID_FB:   write_ok = (d <= motor_cmd_pkg::PCT_FULL);
      motor_cmd_pkg::ADDR_TORQUE:   write_ok = signed_within(d, motor_cmd_pkg::TORQUE_MAX);
      motor_cmd_pkg::ADDR_MOT_LIM:  write_ok = (d <= motor_cmd_pkg::TORQUE_MAX);
      motor_cmd_pkg::ADDR_BRK_LIM:  write_ok = (d <= motor_cmd_pkg::TORQUE_MAX);
      motor_cmd_pkg::ADDR_SPECIAL:  write_ok = ((d & ~motor_cmd_pkg::SPECIAL_MASK) == 16'h0000);
      motor_cmd_pkg::ADDR_VIRT_IN:  write_ok = (d <= motor_cmd_pkg::VIRT_IN_MAX);
      motor_cmd_pkg::ADDR_VIRT_OUT: write_ok = (d <= motor_cmd_pkg::VIRT_OUT_MAX);
      motor_cmd_pkg::ADDR_VOLT_SET: write_ok = (d <= motor_cmd_pkg::PCT_FULL);
      motor_cmd_pkg::ADDR_AO1_SET:  write_ok = signed_within(d, motor_cmd_pkg::PCT_FULL);
      motor_cmd_pkg::ADDR_AO2_SET:  write_ok = signed_within(d, motor_cmd_pkg::PCT_FULL);
      default:                      write_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic        wr_ok;
  logic        rd_only;
  logic        rd_hit;
  logic [15:0] rd_val;
  logic [15:0] state_word_reg;
  logic [15:0] state_word_next;
  logic        dir_rev;
  logic [15:0] freq_ref_next;

  assign wr_ok   = i_reg_wr && write_ok(i_reg_addr, i_reg_wdata, i_fmax);
  assign rd_only = i_reg_rd && !i_reg_wr;

  always_comb begin
    rd_hit = 1'b1;
    case (i_reg_addr)
      motor_cmd_pkg::ADDR_RUN_CMD:   rd_val = o_ctrl.run_command_code;
      motor_cmd_pkg::ADDR_FREQ_SET:  rd_val = o_ctrl.frequency_setpoint;
      motor_cmd_pkg::ADDR_PID_REF:   rd_val = o_ctrl.pid_reference;
      motor_cmd_pkg::ADDR_PID_FB:    rd_val = o_ctrl.pid_feedback;
      motor_cmd_pkg::ADDR_TORQUE:    rd_val = o_ctrl.torque_setpoint;
      motor_cmd_pkg::ADDR_FWD_CEIL:  rd_val = o_ctrl.forward_freq_ceiling;
      motor_cmd_pkg::ADDR_REV_CEIL:  rd_val = o_ctrl.reverse_freq_ceiling;
      motor_cmd_pkg::ADDR_MOT_LIM:   rd_val = o_ctrl.motoring_torque_ceiling;
      motor_cmd_pkg::ADDR_BRK_LIM:   rd_val = o_ctrl.braking_torque_ceiling;
      motor_cmd_pkg::ADDR_SPECIAL:   rd_val = o_ctrl.special_control_word;
      motor_cmd_pkg::ADDR_VIRT_IN:   rd_val = o_ctrl.virtual_input_image;
      motor_cmd_pkg::ADDR_VIRT_OUT:  rd_val = o_ctrl.virtual_output_image;
      motor_cmd_pkg::ADDR_VOLT_SET:  rd_val = o_ctrl.voltage_setpoint;
      motor_cmd_pkg::ADDR_AO1_SET:   rd_val = o_ctrl.analog_out_one_setpoint;
      motor_cmd_pkg::ADDR_AO2_SET:   rd_val = o_ctrl.analog_out_two_setpoint;
      motor_cmd_pkg::ADDR_STATE_ONE: rd_val = state_word_reg;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint registers, stored as written

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl                      <= '0;
      o_ctrl.forward_freq_ceiling <= motor_cmd_pkg::CEIL_RESET;
      o_ctrl.reverse_freq_ceiling <= motor_cmd_pkg::CEIL_RESET;
    end else if (wr_ok) begin
      case (i_reg_addr)
        motor_cmd_pkg::ADDR_RUN_CMD:  o_ctrl.run_command_code        <= i_reg_wdata;
        motor_cmd_pkg::ADDR_FREQ_SET: o_ctrl.frequency_setpoint      <= i_reg_wdata;
        motor_cmd_pkg::ADDR_PID_REF:  o_ctrl.pid_reference           <= i_reg_wdata;
        motor_cmd_pkg::ADDR_PID_FB:   o_ctrl.pid_feedback            <= i_reg_wdata;
        motor_cmd_pkg::ADDR_TORQUE:   o_ctrl.torque_setpoint         <= i_reg_wdata;
        motor_cmd_pkg::ADDR_FWD_CEIL: o_ctrl.forward_freq_ceiling    <= i_reg_wdata;
        motor_cmd_pkg::ADDR_REV_CEIL: o_ctrl.reverse_freq_ceiling    <= i_reg_wdata;
        motor_cmd_pkg::ADDR_MOT_LIM:  o_ctrl.motoring_torque_ceiling <= i_reg_wdata;
        motor_cmd_pkg::ADDR_BRK_LIM:  o_ctrl.braking_torque_ceiling  <= i_reg_wdata;
        motor_cmd_pkg::ADDR_SPECIAL:  o_ctrl.special_control_word    <= i_reg_wdata;
        motor_cmd_pkg::ADDR_VIRT_IN:  o_ctrl.virtual_input_image     <= i_reg_wdata;
        motor_cmd_pkg::ADDR_VIRT_OUT: o_ctrl.virtual_output_image    <= i_reg_wdata;
        motor_cmd_pkg::ADDR_VOLT_SET: o_ctrl.voltage_setpoint        <= i_reg_wdata;
        motor_cmd_pkg::ADDR_AO1_SET:  o_ctrl.analog_out_one_setpoint <= i_reg_wdata;
        motor_cmd_pkg::ADDR_AO2_SET:  o_ctrl.analog_out_two_setpoint <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access answer, one cycle after the request; a write wins over a read

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_ack   <= 1'b0;
      o_reg_err   <= 1'b0;
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_ack   <= i_reg_wr || i_reg_rd;
      o_reg_err   <= (i_reg_wr && !wr_ok) || (rd_only && !rd_hit);
      o_reg_rdata <= rd_only ? rd_val : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command and special-word pulses

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_strobe  <= 1'b0;
      o_fault_reset <= 1'b0;
      o_jog_stop    <= 1'b0;
      o_energy_clr  <= 1'b0;
    end else begin
      o_cmd_strobe  <= wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD);
      o_fault_reset <= wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD) &&
                       (i_reg_wdata == motor_cmd_pkg::CMD_FAULT_RESET);
      o_jog_stop    <= wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD) &&
                       (i_reg_wdata == motor_cmd_pkg::CMD_JOG_STOP);
      o_energy_clr  <= wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_SPECIAL) &&
                       i_reg_wdata[motor_cmd_pkg::SP_ENERGY_CLR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded images of the special word and virtual terminals

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_special  <= '0;
      o_virt_in  <= 10'h000;
      o_virt_out <= '0;
    end else if (wr_ok) begin
      if (i_reg_addr == motor_cmd_pkg::ADDR_SPECIAL) begin
        o_special.motor_sel       <= i_reg_wdata[motor_cmd_pkg::SP_MOTOR_LSB +: 2];
        o_special.torque_ctrl_off <= i_reg_wdata[motor_cmd_pkg::SP_TORQUE_OFF];
        o_special.preexcite       <= i_reg_wdata[motor_cmd_pkg::SP_PREEXC];
        o_special.dc_brake        <= i_reg_wdata[motor_cmd_pkg::SP_DC_BRAKE];
      end
      if (i_reg_addr == motor_cmd_pkg::ADDR_VIRT_IN) begin
        o_virt_in <= i_reg_wdata[9:0];
      end
      if (i_reg_addr == motor_cmd_pkg::ADDR_VIRT_OUT) begin
        o_virt_out <= i_reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency reference, clamped by the ceiling of the commanded direction

  assign dir_rev = (o_ctrl.run_command_code == motor_cmd_pkg::CMD_REV_RUN) ||
                   (o_ctrl.run_command_code == motor_cmd_pkg::CMD_REV_JOG);
  assign freq_ref_next = umin(umin(o_ctrl.frequency_setpoint, i_fmax),
                              dir_rev ? o_ctrl.reverse_freq_ceiling
                                      : o_ctrl.forward_freq_ceiling);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_freq_ref <= 16'h0000;
    end else begin
      o_freq_ref <= freq_ref_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive state word, fault and power-down take priority

  always_comb begin
    if (i_drive.fault) begin
      state_word_next = motor_cmd_pkg::ST_FAULT;
    end else if (i_drive.undervoltage_power_down_state) begin
      state_word_next = motor_cmd_pkg::ST_POWER_OFF;
    end else if (i_drive.running && i_drive.reverse) begin
      state_word_next = motor_cmd_pkg::ST_REV_RUN;
    end else if (i_drive.running) begin
      state_word_next = motor_cmd_pkg::ST_FWD_RUN;
    end else if (i_drive.preexcited) begin
      state_word_next = motor_cmd_pkg::ST_PREEXC;
    end else begin
      state_word_next = motor_cmd_pkg::ST_STOPPED;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_word_reg <= motor_cmd_pkg::ST_STOPPED;
    end else begin
      state_word_reg <= state_word_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_cmd_store;
    wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD)
      |=> o_cmd_strobe && (o_ctrl.run_command_code == $past(i_reg_wdata));
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command code not stored");

  property p_fault_reset;
    i_reg_wr && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD) &&
      (i_reg_wdata == motor_cmd_pkg::CMD_FAULT_RESET)
      |=> o_fault_reset && o_reg_ack && !o_reg_err ##1
          (!o_fault_reset || $past(i_reg_wr && (i_reg_addr == motor_cmd_pkg::ADDR_RUN_CMD) &&
                                   (i_reg_wdata == motor_cmd_pkg::CMD_FAULT_RESET)));
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault reset pulse wrong");

  property p_fwd_limit;
    !$past(dir_rev) |-> o_freq_ref <= $past(o_ctrl.forward_freq_ceiling);
  endproperty
  a_fwd_limit: assert property (p_fwd_limit) else $error("forward ceiling exceeded");

  property p_rev_limit;
    $past(dir_rev) |-> (o_freq_ref <= $past(o_ctrl.reverse_freq_ceiling)) &&
                       (o_freq_ref <= $past(o_ctrl.frequency_setpoint));
  endproperty
  a_rev_limit: assert property (p_rev_limit) else $error("reverse ceiling exceeded");

  property p_pid_range;
    (o_ctrl.pid_reference <= motor_cmd_pkg::PCT_FULL) &&
      (o_ctrl.pid_feedback <= motor_cmd_pkg::PCT_FULL);
  endproperty
  a_pid_range: assert property (p_pid_range) else $error("pid value out of range");

  property p_torque_range;
    signed_within(o_ctrl.torque_setpoint, motor_cmd_pkg::TORQUE_MAX);
  endproperty
  a_torque_range: assert property (p_torque_range) else $error("torque out of range");

  property p_refuse;
    i_reg_wr && !wr_ok |=> o_reg_err && o_reg_ack && $stable(o_ctrl);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write altered state");

  property p_motor_sel;
    wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_SPECIAL)
      |=> o_special.motor_sel == $past(i_reg_wdata[1:0]);
  endproperty
  a_motor_sel: assert property (p_motor_sel) else $error("motor select mismatch");

  property p_energy_clr;
    o_energy_clr |-> $past(wr_ok) && ($past(i_reg_addr) == motor_cmd_pkg::ADDR_SPECIAL) &&
                     $past(i_reg_wdata[motor_cmd_pkg::SP_ENERGY_CLR]);
  endproperty
  a_energy_clr: assert property (p_energy_clr) else $error("energy clear without bit");

  property p_virt_in;
    wr_ok && (i_reg_addr == motor_cmd_pkg::ADDR_VIRT_IN)
      |=> o_virt_in == $past(i_reg_wdata[9:0]);
  endproperty
  a_virt_in: assert property (p_virt_in) else $error("virtual input image wrong");

  property p_readback;
    rd_only && (i_reg_addr == motor_cmd_pkg::ADDR_FREQ_SET)
      |=> o_reg_ack && !o_reg_err && (o_reg_rdata == $past(o_ctrl.frequency_setpoint));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_state_ro;
    i_reg_wr && (i_reg_addr == motor_cmd_pkg::ADDR_STATE_ONE) |=> o_reg_err;
  endproperty
  a_state_ro: assert property (p_state_ro) else $error("state word write accepted");

  c_fault_reset: cover property (o_fault_reset);
  c_rev_run: cover property (dir_rev && (o_freq_ref != 16'h0000));
  c_refused: cover property (o_reg_err && o_reg_ack);
  c_energy_clr: cover property (o_energy_clr);

endmodule

//--- sim/reg_master.sv
`timescale 1ns/1ps
module reg_master (
  // clock
  input  wire logic        i_clk_sys,
  // request side
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic [15:0]      o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  // answer side
  input  wire logic        i_reg_ack,
  input  wire logic        i_reg_err,
  input  wire logic [15:0] i_reg_rdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one request, held for its taking edge, answer read with ack
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                      output logic err, output logic [15:0] rdata);
    int n;
    n = 0;
    // idle edge first, so a released strobe is never raised in the same step
    @(posedge i_clk_sys);
    #1;
    o_reg_wr = wr;
    o_reg_rd = !wr;
    o_reg_addr = addr;
    o_reg_wdata = wdata;
    @(posedge i_clk_sys);
    #1;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    // released lines show the inverse, never the stale value
    o_reg_addr = ~addr;
    o_reg_wdata = ~wdata;
    while (i_reg_ack !== 1'b1 && n < 3) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    err = (n == 0) ? i_reg_err : 1'bx;
    rdata = (n == 0) ? i_reg_rdata : 16'hxxxx;
  endtask
endmodule

//--- sim/serial_control_command_registers_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module serial_control_command_registers_tb_top;
  typedef struct packed {logic [15:0] a; logic [15:0] d; logic e;} row_t;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, wr, rd, ack, err, cs, fr, js, ec, e;
  logic [15:0] addr, wdata, rdata, fref, q, fmax = 16'h1388;
  logic [15:0] shadow [16];
  logic [9:0] vin;
  motor_cmd_pkg::drive_status_t drv = '0;
  motor_cmd_pkg::ctrl_regs_t ctrl;
  motor_cmd_pkg::special_t spc;
  motor_cmd_pkg::virt_out_t vout;
  int err_count = 0, comparisons = 0, cycles = 0;
  row_t rows [20] = '{'{16'h2000, 16'h0001, 1'b0}, '{16'h2000, 16'h0009, 1'b1},
    '{16'h2000, 16'h0000, 1'b1}, '{16'h2001, 16'h1388, 1'b0}, '{16'h2001, 16'h1389, 1'b1},
    '{16'h2002, 16'h03e8, 1'b0}, '{16'h2003, 16'h03e9, 1'b1}, '{16'h2004, 16'hf448, 1'b0},
    '{16'h2004, 16'hf447, 1'b1}, '{16'h2005, 16'h0800, 1'b0}, '{16'h2006, 16'h0100, 1'b0},
    '{16'h2007, 16'h0bb8, 1'b0}, '{16'h2008, 16'h0bb9, 1'b1}, '{16'h2009, 16'h0040, 1'b1},
    '{16'h200a, 16'h03ff, 1'b0}, '{16'h200b, 16'h0010, 1'b1}, '{16'h200c, 16'h03e8, 1'b0},
    '{16'h200d, 16'hfc18, 1'b0}, '{16'h200e, 16'h03e9, 1'b1}, '{16'h2100, 16'h0001, 1'b1}};
  logic [4:0] dv [6] = '{5'b10110, 5'b01010, 5'b11000, 5'b10000, 5'b00001, 5'b00000};
  logic [15:0] dst [6] = '{16'h0004, 16'h0005, 16'h0002, 16'h0001, 16'h0006, 16'h0003};
  always #5 i_clk_sys = ~i_clk_sys;
  reg_master master (.i_clk_sys(i_clk_sys), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .i_reg_ack(ack), .i_reg_err(err), .i_reg_rdata(rdata));
  motor_cmd_regs dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_ack(ack), .o_reg_err(err),
    .o_reg_rdata(rdata), .i_fmax(fmax), .i_drive(drv), .o_cmd_strobe(cs),
    .o_fault_reset(fr), .o_jog_stop(js), .o_energy_clr(ec), .o_ctrl(ctrl),
    .o_freq_ref(fref), .o_special(spc), .o_virt_in(vin), .o_virt_out(vout));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic reset_pulse();
    @(posedge i_clk_sys);
    #1 i_rst = 1'b1;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    foreach (shadow[k]) shadow[k] = (k == 5 || k == 6) ? 16'hffff : 16'h0000;
  endtask
  task automatic check_all();
    for (int k = 0; k < 15; k++) begin
      master.xfer(1'b0, 16'h2000 + 16'(k), 16'h0000, e, q);
      `CHK("readback", shadow[k], q)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_pulse();
    check_all();
    foreach (rows[i]) begin
      master.xfer(1'b1, rows[i].a, rows[i].d, e, q);
      `CHK("write err", rows[i].e, e)
      if (!rows[i].e) shadow[rows[i].a[3:0]] = rows[i].d;
    end
    check_all();
    $display("test table done");
    for (int c = 1; c <= 8; c++) begin
      master.xfer(1'b1, 16'h2000, c[15:0], e, q);
      `CHK("cmd strobe", 1'b1, cs)
      `CHK("fault reset", c == 7, fr)
      `CHK("jog stop", c == 8, js)
      `CHK("stored cmd", c[15:0], ctrl.run_command_code)
    end
    master.xfer(1'b1, 16'h2001, 16'h1000, e, q);
    master.xfer(1'b1, 16'h2000, 16'h0001, e, q);
    @(posedge i_clk_sys);
    #1 `CHK("fwd ref", 16'h0800, fref)
    fmax = 16'h0400;
    @(posedge i_clk_sys);
    #1 `CHK("fmax clamp", 16'h0400, fref)
    fmax = 16'h1388;
    master.xfer(1'b1, 16'h2000, 16'h0004, e, q);
    @(posedge i_clk_sys);
    #1 `CHK("rev ref", 16'h0100, fref)
    master.xfer(1'b1, 16'h2009, 16'h0035, e, q);
    `CHK("special", 5'b01111, spc)
    `CHK("energy idle", 1'b0, ec)
    master.xfer(1'b1, 16'h2009, 16'h000a, e, q);
    `CHK("special", 5'b10000, spc)
    `CHK("energy clear", 1'b1, ec)
    master.xfer(1'b1, 16'h200b, 16'h0009, e, q);
    `CHK("virt out", 4'b1001, vout)
    `CHK("virt in", 10'h3ff, vin)
    master.xfer(1'b0, 16'h200f, 16'h0000, e, q);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 16'h0000, q)
    $display("test commands done");
    foreach (dv[i]) begin
      drv = dv[i];
      @(posedge i_clk_sys);
      #1 master.xfer(1'b0, 16'h2100, 16'h0000, e, q);
      `CHK("state word", dst[i], q)
    end
    $display("test state word done");
    reset_pulse();
    check_all();
    $display("test reset done");
    stop_test();
  end
endmodule
